// ---- pld_array.sv ----
// Holds the sixteen-macrocell sum-of-products array with its config store.
// Assumes a word-addressed register port and pins sampled on core_clk.
// What this block does
// - Four inputs, two clocks, sixteen configurable pins.
// - Ten terms: eight logic, clear, enable/clock.
// - Twenty array inputs, true and complement, feed 160 product terms.
// - True and complement connected forces term low.
// - Open input pair is don't care.
// - All inputs open gives term high.
// - Erased terms connect everything, stay low.
// - Rising global clocks, each one bank.
// - Mode zero: term enables driver, global clock.
// - Mode one: driver on, term clocks register.
// - One bit per pin picks mode.
// - Combinatorial or D/T/JK/SR, selectable polarity.
// - Clear term zeroes register at once.
// - Registers clear at power-up.
// - Feedback selects register or pin.
// - Eight terms ORed, or split two ways.
// - No output plus pin feedback gives input.
`timescale 1ns/1ps
module pld_array
	import pld_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [pld_pkg::ADDR_W-1:0] addr,
	input wire logic [pld_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [pld_pkg::DATA_W-1:0] rdata,
	input wire logic [pld_pkg::N_DED-1:0] ded_in,
	input wire logic global_clock_upper_bank,
	input wire logic global_clock_lower_bank,
	input wire logic [pld_pkg::N_MC-1:0] io_in,
	output logic [pld_pkg::N_MC-1:0] io_out,
	output logic [pld_pkg::N_MC-1:0] io_oe
);
	import pld_pkg::*;

	// Evaluates one product term over the array inputs.
	function automatic logic pt_eval(input logic [ARRAY_W-1:0] mask,
		input logic [N_ARRAY_IN-1:0] x);
		logic r;
		r = 1'b1;
		for (int i = 0; i < N_ARRAY_IN; i++) begin
			if (mask[2*i] && !x[i])
				r = 1'b0;
			if (mask[2*i+1] && x[i])
				r = 1'b0;
		end
		return r;
	endfunction

	// Next register value for the selected flip-flop type.
	function automatic logic ff_next(input logic [2:0] kind,
		input logic a, input logic b, input logic q);
		logic r;
		r = q;
		case (kind)
			TYPE_T: r = q ^ a;
			TYPE_JK: r = (a & ~q) | (~b & q);
			TYPE_SR: r = a | (~b & q);
			default: r = a;
		endcase
		return r;
	endfunction

	logic [N_SYNC-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
	logic [1:0] gclk_prev_reg;
	logic [ARRAY_W-1:0] pt_mask_reg [N_PT];
	logic [CFG_W-1:0] mc_cfg_reg [N_MC];
	logic [N_MC-1:0] mc_q_reg;
	logic [N_MC-1:0] oec_prev_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [N_MC-1:0] io_out_reg, io_oe_reg;
	logic [N_MC-1:0] pin_fb, fb_vec, clr_vec, oec_vec, mode_vec, noout_vec;
	logic [N_MC-1:0] sum_a, sum_b, clk_edge, data_vec, oe_next;
	logic [N_DED-1:0] ded_fb;
	logic [1:0] gclk_edge;
	logic [N_ARRAY_IN-1:0] arr_in;
	logic [N_PT-1:0] pt_val;

	// Three-stage sampling of every pin; a bit changes once the last two stages agree.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			filt_reg <= '0;
		end else begin
			sync1_reg <= {global_clock_upper_bank,
				global_clock_lower_bank, ded_in, io_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg <= (sync2_reg & sync3_reg) |
				(filt_reg & (sync2_reg ^ sync3_reg));
		end
	end

	assign pin_fb = filt_reg[N_MC-1:0];
	assign ded_fb = filt_reg[N_MC+N_DED-1:N_MC];

	// Remembers the global clock levels to find rising edges.
	always_ff @(posedge core_clk) begin
		if (rst)
			gclk_prev_reg <= '0;
		else
			gclk_prev_reg <= filt_reg[N_SYNC-1:N_SYNC-2];
	end

	// Bit 1 is the upper bank clock, bit 0 the lower bank clock.
	assign gclk_edge = filt_reg[N_SYNC-1:N_SYNC-2] & ~gclk_prev_reg;

	// Product term connection store, written two words per term.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < N_PT; i++)
				pt_mask_reg[i] <= PT_ERASED;
		end else if (wr_en && addr < PT_WORDS) begin
			if (addr[0])
				pt_mask_reg[addr[ADDR_W-1:1]][ARRAY_W-1:DATA_W] <=
					wdata[HI_W-1:0];
			else
				pt_mask_reg[addr[ADDR_W-1:1]][DATA_W-1:0] <= wdata;
		end
	end

	// Macrocell configuration store, erased to the default at reset.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int m = 0; m < N_MC; m++)
				mc_cfg_reg[m] <= CFG_ERASED;
		end else if (wr_en && addr >= MC_CFG_BASE &&
			addr < MC_CFG_BASE + 9'(N_MC)) begin
			mc_cfg_reg[4'(addr - MC_CFG_BASE)] <= wdata[CFG_W-1:0];
		end
	end

	// Feedback selection and the array input vector.
	always_comb begin
		for (int m = 0; m < N_MC; m++) begin
			case (mc_cfg_reg[m][CFG_FB_LSB +: 2])
				FB_PIN: fb_vec[m] = pin_fb[m];
				FB_REG: fb_vec[m] = mc_q_reg[m];
				default: fb_vec[m] = 1'b0;
			endcase
		end
		arr_in = {fb_vec, ded_fb};
	end

	// Evaluates all 160 product terms.
	always_comb begin
		for (int p = 0; p < N_PT; p++)
			pt_val[p] = pt_eval(pt_mask_reg[p], arr_in);
	end

	// Per-macrocell OR gates, clear, enable/clock and clock choice.
	always_comb begin
		for (int m = 0; m < N_MC; m++) begin
			logic split;
			split = 1'b0;
			split = mc_cfg_reg[m][CFG_TYPE_LSB +: 3] == TYPE_JK ||
				mc_cfg_reg[m][CFG_TYPE_LSB +: 3] == TYPE_SR;
			sum_a[m] = 1'b0;
			sum_b[m] = 1'b0;
			for (int k = 0; k < N_LOGIC_PT; k++) begin
				if (split && k >= SPLIT_PT)
					sum_b[m] = sum_b[m] | pt_val[m*PT_PER_MC+k];
				else
					sum_a[m] = sum_a[m] | pt_val[m*PT_PER_MC+k];
			end
			clr_vec[m] = pt_val[m*PT_PER_MC+PT_CLR];
			oec_vec[m] = pt_val[m*PT_PER_MC+PT_OEC];
			mode_vec[m] = mc_cfg_reg[m][CFG_MODE_BIT];
			noout_vec[m] = mc_cfg_reg[m][CFG_NOOUT_BIT];
			if (mode_vec[m])
				clk_edge[m] = oec_vec[m] & ~oec_prev_reg[m];
			else if (m < N_BANK)
				clk_edge[m] = gclk_edge[0];
			else
				clk_edge[m] = gclk_edge[1];
		end
	end

	// Remembers the enable/clock terms to find array clock edges.
	always_ff @(posedge core_clk) begin
		if (rst)
			oec_prev_reg <= '0;
		else
			oec_prev_reg <= oec_vec;
	end

	// Macrocell registers: clear wins over any clock edge.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mc_q_reg <= '0;
		end else begin
			for (int m = 0; m < N_MC; m++) begin
				if (clr_vec[m])
					mc_q_reg[m] <= 1'b0;
				else if (clk_edge[m])
					mc_q_reg[m] <= ff_next(
						mc_cfg_reg[m][CFG_TYPE_LSB +: 3],
						sum_a[m], sum_b[m], mc_q_reg[m]);
			end
		end
	end

	// Output data with polarity; a live clear term masks the register.
	always_comb begin
		for (int m = 0; m < N_MC; m++) begin
			logic d;
			d = 1'b0;
			if (mc_cfg_reg[m][CFG_TYPE_LSB +: 3] == TYPE_COMB)
				d = sum_a[m];
			else
				d = mc_q_reg[m] & ~clr_vec[m];
			data_vec[m] = mc_cfg_reg[m][CFG_POL_BIT] ? d : ~d;
			if (noout_vec[m])
				oe_next[m] = 1'b0;
			else if (mode_vec[m])
				oe_next[m] = 1'b1;
			else
				oe_next[m] = oec_vec[m];
		end
	end

	// Pin drivers come from flip-flops.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			io_out_reg <= '0;
			io_oe_reg <= '0;
		end else begin
			io_out_reg <= data_vec;
			io_oe_reg <= oe_next;
		end
	end

	// Read port: data stand for the one cycle after the strobe.
	always_ff @(posedge core_clk) begin
		if (rst || !rd_en)
			rdata_reg <= '0;
		else if (addr < PT_WORDS)
			rdata_reg <= addr[0] ?
				DATA_W'(pt_mask_reg[addr[ADDR_W-1:1]][ARRAY_W-1:DATA_W]) :
				pt_mask_reg[addr[ADDR_W-1:1]][DATA_W-1:0];
		else if (addr < MC_CFG_BASE + 9'(N_MC))
			rdata_reg <= DATA_W'(mc_cfg_reg[4'(addr - MC_CFG_BASE)]);
		else if (addr == STATUS_ADDR)
			rdata_reg <= {pin_fb, mc_q_reg};
		else
			rdata_reg <= '0;
	end

	assign rdata = rdata_reg;
	assign io_out = io_out_reg;
	assign io_oe = io_oe_reg;

	default clocking cb @(posedge core_clk);
	endclocking

	// Reset leaves every register cleared and every term low.
	property p_power_clear;
		rst |=> (mc_q_reg == '0) && (pt_val == '0);
	endproperty
	a_power_clear: assert property (p_power_clear)
		else $error("Reset did not clear registers and terms.");

	// A high clear term leaves the register at zero next cycle.
	property p_clear;
		disable iff (rst) 1'b1 |=> (($past(clr_vec) & mc_q_reg) == '0);
	endproperty
	a_clear: assert property (p_clear)
		else $error("Register not cleared by its clear term.");

	// A term with nothing connected is high.
	property p_open_high;
		disable iff (rst) (pt_mask_reg[9] == '0) |-> pt_val[9];
	endproperty
	a_open_high: assert property (p_open_high)
		else $error("Fully open product term is not high.");

	// A term with both forms of an input connected is low.
	property p_conflict_low;
		disable iff (rst) (pt_mask_reg[1][3:2] == 2'h3) |-> !pt_val[1];
	endproperty
	a_conflict_low: assert property (p_conflict_low)
		else $error("Conflicting connection did not force term low.");

	// Mode one drives the pin permanently unless output is off.
	property p_mode1_oe;
		disable iff (rst)
		1'b1 |=> (($past(mode_vec & ~noout_vec) & ~io_oe) == '0);
	endproperty
	a_mode1_oe: assert property (p_mode1_oe)
		else $error("Mode one pin driver not enabled.");

	// Mode zero follows the enable term with one cycle of latency.
	property p_mode0_oe;
		disable iff (rst) (!mode_vec[2] && !noout_vec[2])
			|=> io_oe[2] == $past(oec_vec[2]);
	endproperty
	a_mode0_oe: assert property (p_mode0_oe)
		else $error("Mode zero enable does not follow its term.");

	// Without its bank's clock edge a mode zero register holds.
	property p_bank_hold;
		disable iff (rst)
		(!mode_vec[0] && !gclk_edge[0] && !clr_vec[0])
			|=> $stable(mc_q_reg[0]);
	endproperty
	a_bank_hold: assert property (p_bank_hold)
		else $error("Lower bank register moved without its clock.");

	// A D register loads its sum on an active edge.
	property p_d_load;
		disable iff (rst)
		(mc_cfg_reg[8][CFG_TYPE_LSB +: 3] == TYPE_D && clk_edge[8] &&
			!clr_vec[8]) |=> mc_q_reg[8] == $past(sum_a[8]);
	endproperty
	a_d_load: assert property (p_d_load)
		else $error("D register did not load its input.");

	// In mode one the register moves only on its term's rising edge.
	property p_array_clock;
		disable iff (rst)
		(mode_vec[0] && !clr_vec[0] &&
			!(oec_vec[0] && !oec_prev_reg[0])) |=> $stable(mc_q_reg[0]);
	endproperty
	a_array_clock: assert property (p_array_clock)
		else $error("Array clocked register moved without its edge.");

	// A JK register with both inputs high toggles on an active edge.
	property p_jk_toggle;
		disable iff (rst)
		(mc_cfg_reg[8][CFG_TYPE_LSB +: 3] == TYPE_JK && clk_edge[8] &&
			!clr_vec[8] && sum_a[8] && sum_b[8])
			|=> mc_q_reg[8] != $past(mc_q_reg[8]);
	endproperty
	a_jk_toggle: assert property (p_jk_toggle)
		else $error("JK register did not toggle.");

	// An SR register with its set input high ends at one; set wins.
	property p_sr_set;
		disable iff (rst)
		(mc_cfg_reg[8][CFG_TYPE_LSB +: 3] == TYPE_SR && clk_edge[8] &&
			!clr_vec[8] && sum_a[8]) |=> mc_q_reg[8];
	endproperty
	a_sr_set: assert property (p_sr_set)
		else $error("SR register did not set.");
endmodule // pld_array

// ---- pld_pkg.sv ----
// Holds the constants shared by the macrocell array design.
// Assumes a 32-bit register port with word addresses.
package pld_pkg;
	localparam int N_DED = 4;
	localparam int N_MC = 16;
	localparam int N_BANK = 8;
	localparam int PT_PER_MC = 10;
	localparam int N_LOGIC_PT = 8;
	localparam int SPLIT_PT = 4;
	localparam int PT_CLR = 8;
	localparam int PT_OEC = 9;
	localparam int N_ARRAY_IN = N_DED + N_MC;
	localparam int ARRAY_W = 2 * N_ARRAY_IN;
	localparam int N_PT = N_MC * PT_PER_MC;
	localparam int N_SYNC = N_MC + N_DED + 2;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int HI_W = ARRAY_W - DATA_W;
	localparam int CFG_W = 8;
	// Word map: two words per product term, then macrocell configs.
	localparam logic [ADDR_W-1:0] PT_WORDS = 9'h140;
	localparam logic [ADDR_W-1:0] MC_CFG_BASE = 9'h140;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 9'h150;
	// Macrocell config fields.
	localparam int CFG_TYPE_LSB = 0;
	localparam int CFG_POL_BIT = 3;
	localparam int CFG_NOOUT_BIT = 4;
	localparam int CFG_FB_LSB = 5;
	localparam int CFG_MODE_BIT = 7;
	localparam logic [2:0] TYPE_COMB = 3'h0;
	localparam logic [2:0] TYPE_D = 3'h1;
	localparam logic [2:0] TYPE_T = 3'h2;
	localparam logic [2:0] TYPE_JK = 3'h3;
	localparam logic [2:0] TYPE_SR = 3'h4;
	localparam logic [1:0] FB_PIN = 2'h0;
	localparam logic [1:0] FB_REG = 2'h1;
	// Erased state: combinatorial, active low, output on, pin feedback.
	localparam logic [CFG_W-1:0] CFG_ERASED = 8'h00;
	localparam logic [ARRAY_W-1:0] PT_ERASED = 40'hff_ffff_ffff;
endpackage

// ---- board_model.sv ----
// Holds a board model that resolves the sixteen I/O pins of the array.
// Assumes the bench sets the far-side drive of each pin with ext_en/ext_val.
`timescale 1ns/1ps
module board_model
	import pld_pkg::*;
(
	input wire logic core_clk,
	input wire logic [pld_pkg::N_MC-1:0] io_out,
	input wire logic [pld_pkg::N_MC-1:0] io_oe,
	input wire logic [pld_pkg::N_MC-1:0] ext_en,
	input wire logic [pld_pkg::N_MC-1:0] ext_val,
	output logic [pld_pkg::N_MC-1:0] io_in
);
	logic [N_MC-1:0] float_reg = '0;

	// A pin with no driver has no pull, so its level wanders each cycle.
	always_ff @(posedge core_clk) begin
		float_reg <= ~float_reg;
	end

	// The device driver wins, then the board, then the wandering level.
	always_comb begin
		for (int m = 0; m < N_MC; m++) begin
			io_in[m] = ext_en[m] ? ext_val[m] : float_reg[m];
			if (io_oe[m]) begin
				io_in[m] = io_out[m];
			end
		end
	end
endmodule // board_model

// ---- sum_of_products_macrocell_array_test.sv ----
// Holds the self-checking bench for the macrocell array.
// Assumes pld_pkg, pld_array and board_model are compiled before it.
`timescale 1ns/1ps
module sum_of_products_macrocell_array_test;
	import pld_pkg::*;
	logic core_clk, rst, wr_en, rd_en, gclk_up, gclk_lo;
	logic rd_d = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [N_DED-1:0] ded_in;
	logic [N_MC-1:0] io_in, io_out, io_oe, ext_en, ext_val;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] msk_q[$];
	int num_errors = 0;
	int samples_checked = 0;

	pld_array pld_array_i (.core_clk(core_clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.ded_in(ded_in), .global_clock_upper_bank(gclk_up),
		.global_clock_lower_bank(gclk_lo), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));
	board_model board_model_i (.core_clk(core_clk), .io_out(io_out),
		.io_oe(io_oe), .ext_en(ext_en), .ext_val(ext_val), .io_in(io_in));

	// Runs the 50 MHz core clock.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] e);
		samples_checked++;
		if (seen !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, e, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	// Notes the expected masked answer, then issues the read.
	task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e, logic [31:0] m);
		@(posedge core_clk);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
	endtask

	task automatic set_term(int p, logic [ARRAY_W-1:0] m);
		wr(ADDR_W'(2 * p), m[31:0]);
		wr(ADDR_W'(2 * p + 1), {24'h0, m[39:32]});
	endtask

	// Gives one bank clock a pulse long enough to pass the pin filter.
	task automatic gpulse(bit up);
		repeat (8) @(posedge core_clk);
		gclk_up <= up;
		gclk_lo <= !up;
		repeat (4) @(posedge core_clk);
		gclk_up <= 1'b0;
		gclk_lo <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask

	// Compares each read answer with the oldest note in the queue.
	always @(posedge core_clk) begin
		if (rd_d) begin
			check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
		end
		rd_d <= rd_en;
	end

	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge core_clk);
		check("timeout", 1, 0);
		close_out();
	end

	// Runs the scenarios in order.
	initial begin
		rst = 1'b1;
		{wr_en, rd_en, gclk_up, gclk_lo} = '0;
		addr = '0;
		wdata = '0;
		ded_in = '0;
		ext_en = '0;
		ext_val = '0;
		void'($urandom(32'h7edf759f));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("erased out", io_out[0], 1);
		check("erased oe", io_oe[0], 0);
		rd(9'h000, 32'hffff_ffff, '1);
		rd(9'h001, 32'h0000_00ff, '1);
		rd(MC_CFG_BASE, 0, '1);
		rd(STATUS_ADDR, 0, 32'hffff);
		rd(9'h1ff, 0, '1);
		$display("test erased done");
		set_term(0, 40'h1);
		set_term(1, 40'hc);
		set_term(9, 40'h0);
		wr(MC_CFG_BASE, 32'h08);
		for (int n = 0; n < 6; n++) begin
			ded_in <= N_DED'($urandom);
			repeat (8) @(posedge core_clk);
			check("comb out", io_out[0], ded_in[0]);
			check("comb oe", io_oe[0], 1);
		end
		wr(MC_CFG_BASE, 32'h00);
		repeat (8) @(posedge core_clk);
		check("low out", io_out[0], !ded_in[0]);
		wr(MC_CFG_BASE + 2, 32'h10);
		set_term(0, 40'h1000);
		ext_en <= 16'h0004;
		for (int v = 0; v < 2; v++) begin
			ext_val <= 16'(v << 2);
			repeat (10) @(posedge core_clk);
			check("pin fb", io_out[0], !v[0]);
			check("input oe", io_oe[2], 0);
		end
		set_term(9, PT_ERASED);
		wr(MC_CFG_BASE, 32'h81);
		repeat (3) @(posedge core_clk);
		check("mode1 oe", io_oe[0], 1);
		$display("test comb done");
		set_term(80, 40'h4);
		set_term(89, 40'h0);
		wr(MC_CFG_BASE + 8, 32'h09);
		ded_in <= 4'h2;
		gpulse(0);
		rd(STATUS_ADDR, 0, 32'h100);
		gpulse(1);
		rd(STATUS_ADDR, 32'h100, 32'h100);
		check("reg out", io_out[8], 1);
		wr(MC_CFG_BASE + 8, 32'h0a);
		gpulse(1);
		rd(STATUS_ADDR, 0, 32'h100);
		gpulse(1);
		rd(STATUS_ADDR, 32'h100, 32'h100);
		set_term(88, 40'h0);
		rd(STATUS_ADDR, 0, 32'h100);
		gpulse(1);
		rd(STATUS_ADDR, 0, 32'h100);
		repeat (3) @(posedge core_clk);
		$display("test registers done");
		set_term(9, 40'h40);
		rd(STATUS_ADDR, 0, 32'h1);
		ded_in <= 4'ha;
		repeat (8) @(posedge core_clk);
		rd(STATUS_ADDR, 1, 32'h1);
		check("array clk out", io_out[0], 0);
		ext_val <= '0;
		ded_in <= 4'h2;
		repeat (8) @(posedge core_clk);
		rd(STATUS_ADDR, 1, 32'h1);
		ded_in <= 4'ha;
		repeat (8) @(posedge core_clk);
		rd(STATUS_ADDR, 0, 32'h1);
		$display("test array clock done");
		set_term(88, PT_ERASED);
		set_term(84, 40'h4);
		wr(MC_CFG_BASE + 8, 32'h0b);
		gpulse(1);
		rd(STATUS_ADDR, 32'h100, 32'h100);
		gpulse(1);
		rd(STATUS_ADDR, 0, 32'h100);
		wr(MC_CFG_BASE + 8, 32'h0c);
		gpulse(1);
		rd(STATUS_ADDR, 32'h100, 32'h100);
		set_term(80, PT_ERASED);
		gpulse(1);
		rd(STATUS_ADDR, 0, 32'h100);
		repeat (3) @(posedge core_clk);
		$display("test jk sr done");
		close_out();
	end
endmodule // sum_of_products_macrocell_array_test
